// ### include/wake_seq_defines.vh
// register offsets, field positions, reset values and timing constants of the wake/power sequencer
`ifndef WAKE_SEQ_DEFINES_VH
`define WAKE_SEQ_DEFINES_VH
`define SYSCTL1_IDX        8'h03
`define WAKE_STAT_IDX      8'h1F
`define WAKE_MASK_IDX      8'h27
`define SEQ_STATUS_IDX     8'h40
`define SYSCTL1_ADDR       12'h00C
`define WAKE_STAT_ADDR     12'h07C
`define WAKE_MASK_ADDR     12'h09C
`define SEQ_STATUS_ADDR    12'h100
`define CHIP_ON_BIT        15
`define KEY_DEB_BIT        3
`define KEY_POL_BIT        1
`define SYSCTL1_RESET      16'h0002
`define WAKE_MASK_RESET    7'h00
`define FLAG_OFF           6
`define FLAG_SLEEP         5
`define FLAG_CONV          4
`define FLAG_WDOG          3
`define FLAG_GPON          2
`define FLAG_KEY           1
`define FLAG_GWAKE         0
`define NUM_SLOTS          14
`define CLK_HZ             10000000
`define SLOT_US            1280
`define START_QUAL_MS      40
`define GPOFF_QUAL_MS      5
`define KEY_OFF_LONG_S     10
`define KEY_OFF_SHORT_S    5
`define WDOG_FAULT_LIMIT   7
`endif

// ### rtl/wake_status_and_power_sequencer.v
// wake status flags, fourteen-slot power-up sequencer and shutdown control with an APB slave
//
// Overview of operation
// [R1] set woke-from-off flag on rising edge of start-up out of off
// [R2] set woke-from-sleep flag on rising edge of start-up out of hibernate
// [R3] set converter fault flag when wakeup followed a converter fault reset
// [R4] set watchdog flag when wakeup followed a missed watchdog heartbeat reset
// [R5] set gpio power-on flag when that input qualified past its time
// [R6] set power key flag when the key qualified past its time
// [R7] set gpio wake flag when that input qualified past its time
// [R8] flags latch on event rising edge, clear when status is read
// [R9] mask register bits 6..0, one per flag, 1 masks, reset 0
// [R10] active command runs fourteen timeslots, each supply enabled in its slot
// [R11] advance slot after about 1.28ms once slot supplies reach 90 percent
// [R12] writing chip-on bit 15 to 0 in active or sleep shuts down
// [R13] gpio power-off input active over 5ms is a shutdown event
// [R14] key held over 10s shuts down; debounce select bit 3 gives 5s
// [R15] key polarity bit 1, default 1: 0 active high, 1 active low
// [R16] watchdog timeout after seven prior faults is a shutdown event
// [R17] programmed shutdown faults and thermal shutdown also go to off
// [R18] chip-on bit is set to 1 during start-up
// [R19] shutdown asserts resets, clears registers and chip-on, then enters off
// [R20] off state restarts on any valid start-up event
// [R21] key qualifies as start-up only after active over 40ms
// [R22] first-level wake interrupt raised when any flag is set
// [R23] masked flag still latches and reads, but gives no interrupt
`timescale 1ns/1ps
`include "wake_seq_defines.vh"
module wake_status_and_power_sequencer #(
   parameter integer CLK_HZ        = `CLK_HZ,
   parameter integer SLOT_CYCLES   = (`CLK_HZ / 1000000) * `SLOT_US,
   parameter integer START_CYCLES  = (`CLK_HZ / 1000) * `START_QUAL_MS,
   parameter integer GPOFF_CYCLES  = (`CLK_HZ / 1000) * `GPOFF_QUAL_MS,
   parameter integer KEY_LONG_CYC  = `CLK_HZ * `KEY_OFF_LONG_S,
   parameter integer KEY_SHORT_CYC = `CLK_HZ * `KEY_OFF_SHORT_S
) (
   input  wire        REF_CLK_I,
   input  wire        RST_N_I,
   input  wire        PSEL_I,
   input  wire        PENABLE_I,
   input  wire        PWRITE_I,
   input  wire [11:0] PADDR_I,
   input  wire [31:0] PWDATA_I,
   output reg  [31:0] PRDATA_O,
   output reg         PREADY_O,
   output reg         PSLVERR_O,
   input  wire        POWER_KEY_I,
   input  wire        GPIO_POWER_ON_INPUT_I,
   input  wire        GPIO_POWER_OFF_INPUT_I,
   input  wire        GPIO_WAKE_INPUT_I,
   input  wire        CONVERTER_FAULT_RESET_I,
   input  wire        WATCHDOG_RESET_I,
   input  wire        WATCHDOG_TIMEOUT_I,
   input  wire        SHUTDOWN_FAULT_I,
   input  wire        THERMAL_SHUTDOWN_I,
   input  wire        HIBERNATE_REQ_I,
   input  wire [13:0] SLOT_SUPPLY_MAP_I,
   input  wire [13:0] SUPPLY_GOOD_I,
   output reg  [13:0] SUPPLY_ENABLE_O,
   output reg         FIRST_LEVEL_WAKE_IRQ_O,
   output reg         HOST_RESET_N_O,
   output reg         MEMORY_RESET_OUT_N_O,
   output reg         CHIP_ACTIVE_O
);
   localparam [2:0] ST_OFF  = 3'h0;
   localparam [2:0] ST_SEQ  = 3'h1;
   localparam [2:0] ST_ACT  = 3'h2;
   localparam [2:0] ST_HIB  = 3'h3;
   localparam [2:0] ST_SHUT = 3'h4;

   // two-flop synchronisers for pins
   reg  [10:0] s1_q;
   reg  [10:0] s2_q;
   wire [10:0] pins = {HIBERNATE_REQ_I, THERMAL_SHUTDOWN_I, SHUTDOWN_FAULT_I, WATCHDOG_TIMEOUT_I,
                       WATCHDOG_RESET_I, CONVERTER_FAULT_RESET_I, GPIO_WAKE_INPUT_I,
                       GPIO_POWER_OFF_INPUT_I, GPIO_POWER_ON_INPUT_I, POWER_KEY_I, 1'b0};
   reg  [13:0] good1_q;
   reg  [13:0] good2_q;

   reg  [2:0]  state_q;
   reg  [3:0]  slot_q;
   reg  [31:0] slot_cnt_q;
   reg  [15:0] ctl_q;
   reg  [6:0]  flags_q;
   reg  [6:0]  mask_q;
   reg  [31:0] key_cnt_q;
   reg  [31:0] gon_cnt_q;
   reg  [31:0] gwk_cnt_q;
   reg  [31:0] goff_cnt_q;
   reg  [2:0]  fault_cnt_q;
   reg         conv_pend_q;
   reg         wdog_pend_q;
   reg         from_hib_q;
   reg         wdog_prev_q;
   reg         key_q_prev_q;
   reg         gon_q_prev_q;
   reg         gwk_q_prev_q;
   reg         started_prev_q;

   function [31:0] qual_count;
      input        active;
      input [31:0] cnt;
      begin
         if (!active)
            qual_count = 32'h0;
         else if (cnt == 32'hFFFFFFFF)
            qual_count = cnt;
         else
            qual_count = cnt + 32'h1;
      end
   endfunction

   // synchronised pin levels; logic reads only the second flop
   wire key_sync   = s2_q[1];
   wire gon_sync   = s2_q[2];
   wire goff_sync  = s2_q[3];
   wire gwk_sync   = s2_q[4];
   wire conv_sync  = s2_q[5];
   wire wrst_sync  = s2_q[6];
   wire wto_sync   = s2_q[7];
   wire fault_sync = s2_q[8];
   wire therm_sync = s2_q[9];

   // the bit of a vector that belongs to one slot
   function [13:0] slot_bit;
      input [13:0] vec;
      input [3:0]  idx;
      begin
         slot_bit = vec & (14'h0001 << idx);
      end
   endfunction

   function addr_is;
      input [11:0] addr;
      input [11:0] ref_addr;
      begin
         addr_is = (addr == ref_addr);
      end
   endfunction

   // register read mux, unmapped offsets read as zero
   function [31:0] read_word;
      input [11:0] addr;
      input [15:0] ctl;
      input [6:0]  flags;
      input [6:0]  mask;
      input [24:0] seq;
      begin
         case (addr)
            `SYSCTL1_ADDR:    read_word = {16'h0000, ctl};
            `WAKE_STAT_ADDR:  read_word = {25'h0, flags};
            `WAKE_MASK_ADDR:  read_word = {25'h0, mask};
            `SEQ_STATUS_ADDR: read_word = {7'h00, seq};
            default:          read_word = 32'h00000000;
         endcase
      end
   endfunction

   wire key_active  = key_sync ^ ctl_q[`KEY_POL_BIT]; // [R15]
   wire key_start   = key_cnt_q > START_CYCLES; // [R21]
   wire gon_start   = gon_cnt_q > START_CYCLES;
   wire gwk_start   = gwk_cnt_q > START_CYCLES;
   wire key_off     = key_cnt_q > (ctl_q[`KEY_DEB_BIT] ? KEY_SHORT_CYC : KEY_LONG_CYC); // [R14]
   wire goff_evt    = goff_cnt_q > GPOFF_CYCLES; // [R13]
   wire wdog_rise   = wto_sync & ~wdog_prev_q;
   wire wdog_off    = wdog_rise & (fault_cnt_q == `WDOG_FAULT_LIMIT); // [R16]

   wire access   = PSEL_I & PENABLE_I & PREADY_O;
   wire wr_en    = access & PWRITE_I;
   wire rd_en    = access & ~PWRITE_I;
   wire setup    = PSEL_I & ~PENABLE_I;
   wire hit_ctl  = addr_is(PADDR_I, `SYSCTL1_ADDR);
   wire hit_stat = addr_is(PADDR_I, `WAKE_STAT_ADDR);
   wire hit_mask = addr_is(PADDR_I, `WAKE_MASK_ADDR);
   wire hit_seq  = addr_is(PADDR_I, `SEQ_STATUS_ADDR);
   wire mapped   = hit_ctl | hit_stat | hit_mask | hit_seq;
   wire sw_off   = wr_en & hit_ctl & ~PWDATA_I[`CHIP_ON_BIT] &
                   ((state_q == ST_ACT) | (state_q == ST_HIB)); // [R12]
   wire shut_evt = sw_off | goff_evt | key_off | wdog_off | fault_sync | therm_sync; // [R17]

   wire slot_good = (slot_bit(SLOT_SUPPLY_MAP_I, slot_q) == 14'h0000) |
                    (slot_bit(good2_q, slot_q) != 14'h0000); // [R11]
   wire slot_done    = (slot_cnt_q + 32'h1) >= SLOT_CYCLES;
   wire started      = (state_q == ST_ACT);
   wire started_rise = started & ~started_prev_q;
   wire [24:0] seq_word = {fault_cnt_q, SUPPLY_ENABLE_O, slot_q, 1'b0, state_q};

   reg  [6:0] set_flags;
   always @* begin
      set_flags = 7'h00;
      set_flags[`FLAG_OFF]   = started_rise & ~from_hib_q; // [R1]
      set_flags[`FLAG_SLEEP] = started_rise & from_hib_q; // [R2]
      set_flags[`FLAG_CONV]  = started_rise & conv_pend_q; // [R3]
      set_flags[`FLAG_WDOG]  = started_rise & wdog_pend_q; // [R4]
      set_flags[`FLAG_GPON]  = gon_start & ~gon_q_prev_q; // [R5]
      set_flags[`FLAG_KEY]   = key_start & ~key_q_prev_q; // [R6]
      set_flags[`FLAG_GWAKE] = gwk_start & ~gwk_q_prev_q; // [R7]
   end

   // qualified edges only, so a pin held through shutdown cannot restart
   wire start_evt = set_flags[`FLAG_GPON] | set_flags[`FLAG_KEY] | set_flags[`FLAG_GWAKE];

   // pin and supply-good synchronisers
   always @(posedge REF_CLK_I) begin
      if (!RST_N_I) begin
         s1_q <= 11'h000;
         s2_q <= 11'h000;
         good1_q <= 14'h0000;
         good2_q <= 14'h0000;
      end else begin
         s1_q <= pins;
         s2_q <= s1_q;
         good1_q <= SUPPLY_GOOD_I;
         good2_q <= good1_q;
      end
   end

   // qualification counters, saturating
   always @(posedge REF_CLK_I) begin
      if (!RST_N_I) begin
         key_cnt_q <= 32'h0;
         gon_cnt_q <= 32'h0;
         gwk_cnt_q <= 32'h0;
         goff_cnt_q <= 32'h0;
      end else begin
         key_cnt_q <= qual_count(key_active, key_cnt_q);
         gon_cnt_q <= qual_count(gon_sync, gon_cnt_q);
         gwk_cnt_q <= qual_count(gwk_sync, gwk_cnt_q);
         goff_cnt_q <= qual_count(goff_sync, goff_cnt_q);
      end
   end

   // previous levels for edge detection
   always @(posedge REF_CLK_I) begin
      if (!RST_N_I) begin
         wdog_prev_q <= 1'b0;
         key_q_prev_q <= 1'b0;
         gon_q_prev_q <= 1'b0;
         gwk_q_prev_q <= 1'b0;
         started_prev_q <= 1'b0;
      end else begin
         wdog_prev_q <= wto_sync;
         key_q_prev_q <= key_start;
         gon_q_prev_q <= gon_start;
         gwk_q_prev_q <= gwk_start;
         started_prev_q <= started;
      end
   end

   // wake flags and mask, both back to defaults on the way to off
   always @(posedge REF_CLK_I) begin
      if (!RST_N_I) begin
         mask_q <= `WAKE_MASK_RESET;
         flags_q <= 7'h00;
      end else if (state_q == ST_SHUT) begin
         mask_q <= `WAKE_MASK_RESET; // [R19]
         flags_q <= 7'h00;
      end else begin
         if (wr_en & hit_mask)
            mask_q <= PWDATA_I[6:0]; // [R9]
         // only bits already reported are cleared; a new set wins
         flags_q <= (flags_q & ~(rd_en & hit_stat ? PRDATA_O[6:0] : 7'h00)) | set_flags; // [R8]
      end
   end

   // reset causes and watchdog fault count
   always @(posedge REF_CLK_I) begin
      if (!RST_N_I) begin
         fault_cnt_q <= 3'h0;
         conv_pend_q <= 1'b0;
         wdog_pend_q <= 1'b0;
      end else begin
         if (wdog_rise & (fault_cnt_q != `WDOG_FAULT_LIMIT))
            fault_cnt_q <= fault_cnt_q + 3'h1;
         if (state_q == ST_ACT) begin
            conv_pend_q <= 1'b0;
            wdog_pend_q <= 1'b0;
         end else begin
            if (conv_sync)
               conv_pend_q <= 1'b1;
            if (wrst_sync)
               wdog_pend_q <= 1'b1;
         end
      end
   end

   // sequencer and control register
   always @(posedge REF_CLK_I) begin
      if (!RST_N_I) begin
         state_q <= ST_OFF;
         slot_q <= 4'h0;
         slot_cnt_q <= 32'h0;
         ctl_q <= `SYSCTL1_RESET;
         from_hib_q <= 1'b0;
         SUPPLY_ENABLE_O <= 14'h0000;
         HOST_RESET_N_O <= 1'b0;
         MEMORY_RESET_OUT_N_O <= 1'b0;
         CHIP_ACTIVE_O <= 1'b0;
      end else begin
         if (wr_en & hit_ctl & (state_q != ST_SHUT))
            ctl_q <= PWDATA_I[15:0];
         case (state_q)
            ST_OFF: begin
               if (start_evt | conv_sync | wrst_sync) begin // [R20]
                  state_q <= ST_SEQ;
                  slot_q <= 4'h0;
                  slot_cnt_q <= 32'h0;
                  from_hib_q <= 1'b0;
                  ctl_q[`CHIP_ON_BIT] <= 1'b1; // [R18]
               end
            end
            ST_SEQ: begin
               SUPPLY_ENABLE_O <= SUPPLY_ENABLE_O | slot_bit(SLOT_SUPPLY_MAP_I, slot_q); // [R10]
               if (shut_evt) begin
                  state_q <= ST_SHUT;
               end else if (slot_done) begin
                  if (slot_good) begin // [R11]
                     slot_cnt_q <= 32'h0;
                     if (slot_q == `NUM_SLOTS - 1) begin
                        state_q <= ST_ACT;
                        HOST_RESET_N_O <= 1'b1;
                        MEMORY_RESET_OUT_N_O <= 1'b1;
                        CHIP_ACTIVE_O <= 1'b1;
                     end else
                        slot_q <= slot_q + 4'h1;
                  end
               end else
                  slot_cnt_q <= slot_cnt_q + 32'h1;
            end
            ST_ACT: begin
               // hibernate entry is not modelled; only shutdown leaves active
               if (shut_evt)
                  state_q <= ST_SHUT;
            end
            ST_HIB: begin
               if (shut_evt)
                  state_q <= ST_SHUT;
               else if (start_evt) begin
                  state_q <= ST_SEQ;
                  from_hib_q <= 1'b1;
               end
            end
            // one cycle of shutdown: resets low, supplies off, defaults back
            ST_SHUT: begin
               HOST_RESET_N_O <= 1'b0; // [R19]
               MEMORY_RESET_OUT_N_O <= 1'b0;
               SUPPLY_ENABLE_O <= 14'h0000;
               CHIP_ACTIVE_O <= 1'b0;
               ctl_q <= `SYSCTL1_RESET;
               state_q <= ST_OFF;
            end
            default: state_q <= ST_OFF;
         endcase
      end
   end

   // apb slave, ready in the cycle after setup
   always @(posedge REF_CLK_I) begin
      if (!RST_N_I) begin
         PRDATA_O <= 32'h0;
         PREADY_O <= 1'b0;
         PSLVERR_O <= 1'b0;
         FIRST_LEVEL_WAKE_IRQ_O <= 1'b0;
      end else begin
         FIRST_LEVEL_WAKE_IRQ_O <= |(flags_q & ~mask_q); // [R22] [R23]
         PREADY_O <= setup;
         PSLVERR_O <= setup & ~mapped;
         // read data is captured at setup and stands through the access cycle
         if (setup & ~PWRITE_I)
            PRDATA_O <= read_word(PADDR_I, ctl_q, flags_q, mask_q, seq_word);
         else
            PRDATA_O <= 32'h00000000;
      end
   end
endmodule // wake_status_and_power_sequencer

// ### sim/supply_model.sv
// behavioural supply bank: each enabled supply reports good after a lag
`timescale 1ns/1ps
module supply_model (
   input  wire        clk_i,
   input  wire        slow_i,
   input  wire [13:0] enable_i,
   output reg  [13:0] good_o
);
   reg [13:0] stage_q [0:31];
   integer    k;
   // slow lag outlasts a slot, so the sequencer must wait
   always @(posedge clk_i) begin
      stage_q[0] <= enable_i;
      for (k = 1; k < 32; k = k + 1) stage_q[k] <= stage_q[k-1] & enable_i;
      good_o <= stage_q[slow_i ? 31 : 3] & enable_i;
   end
endmodule // supply_model

// ### sim/wake_seq_properties.sv
// port assertions for the wake status and power sequencer
`timescale 1ns/1ps
`include "wake_seq_defines.vh"
module wake_seq_properties #(
   parameter integer SLOT_CYCLES  = 20,
   parameter integer GPOFF_CYCLES = 8
) (
   input wire        REF_CLK_I,
   input wire        RST_N_I,
   input wire        PSEL_I,
   input wire        PENABLE_I,
   input wire        PWRITE_I,
   input wire [11:0] PADDR_I,
   input wire [31:0] PWDATA_I,
   input wire [31:0] PRDATA_O,
   input wire        PREADY_O,
   input wire        PSLVERR_O,
   input wire        GPIO_POWER_OFF_INPUT_I,
   input wire        SHUTDOWN_FAULT_I,
   input wire        THERMAL_SHUTDOWN_I,
   input wire [13:0] SUPPLY_ENABLE_O,
   input wire        FIRST_LEVEL_WAKE_IRQ_O,
   input wire        HOST_RESET_N_O,
   input wire        MEMORY_RESET_OUT_N_O,
   input wire        CHIP_ACTIVE_O
);
   reg  [13:0] en_q;
   reg  [15:0] stay_q;
   reg  [15:0] hi_q;
   reg  [6:0]  mask_q;
   wire        acc = PSEL_I & PENABLE_I & PREADY_O;
   wire        st_rd = acc & !PWRITE_I & (PADDR_I == `WAKE_STAT_ADDR);
   wire        mapped = PADDR_I == `SYSCTL1_ADDR || PADDR_I == `WAKE_STAT_ADDR ||
                        PADDR_I == `WAKE_MASK_ADDR || PADDR_I == `SEQ_STATUS_ADDR;
   always @(posedge REF_CLK_I) begin
      en_q   <= RST_N_I ? SUPPLY_ENABLE_O : 14'h0000;
      stay_q <= (SUPPLY_ENABLE_O != en_q) ? 16'h0000 : stay_q + {15'h0000, stay_q != 16'hFFFF};
      hi_q   <= GPIO_POWER_OFF_INPUT_I ? hi_q + {15'h0000, hi_q != 16'hFFFF} : 16'h0000;
      if (!CHIP_ACTIVE_O) mask_q <= 7'h00;
      else if (acc && PWRITE_I && PADDR_I == `WAKE_MASK_ADDR) mask_q <= PWDATA_I[6:0];
   end
   default clocking cb @(posedge REF_CLK_I); endclocking
   default disable iff (!RST_N_I);
   property p_ready; (PSEL_I && !PENABLE_I) |=> PREADY_O; endproperty
   a_ready: assert property (p_ready) else $error("no ready after setup");
   property p_err; (PREADY_O && !mapped) |-> (PSLVERR_O && PRDATA_O == 32'h0); endproperty
   a_err: assert property (p_err) else $error("unmapped access not refused");
   property p_irq; (st_rd && (PRDATA_O[6:0] & ~mask_q) != 7'h00) |-> FIRST_LEVEL_WAKE_IRQ_O; endproperty
   a_irq: assert property (p_irq) else $error("wake irq low with open flag");
   property p_rst; !CHIP_ACTIVE_O |-> (!HOST_RESET_N_O && !MEMORY_RESET_OUT_N_O); endproperty
   a_rst: assert property (p_rst) else $error("resets released while off");
   property p_sd; ((THERMAL_SHUTDOWN_I || SHUTDOWN_FAULT_I) && CHIP_ACTIVE_O) |-> ##[1:6] !CHIP_ACTIVE_O; endproperty
   a_sd: assert property (p_sd) else $error("no shutdown on fault");
   property p_sw;
      (acc && PWRITE_I && PADDR_I == `SYSCTL1_ADDR && !PWDATA_I[15] && CHIP_ACTIVE_O) |-> ##[1:4] !CHIP_ACTIVE_O;
   endproperty
   a_sw: assert property (p_sw) else $error("no software shutdown");
   property p_slot; (SUPPLY_ENABLE_O != en_q && en_q != 0 && SUPPLY_ENABLE_O != 0) |-> stay_q >= SLOT_CYCLES - 2;
   endproperty
   a_slot: assert property (p_slot) else $error("slot advanced early");
   property p_gpoff; (hi_q == GPOFF_CYCLES + 6) |-> !CHIP_ACTIVE_O; endproperty
   a_gpoff: assert property (p_gpoff) else $error("power-off input ignored");
   property p_offen; $fell(CHIP_ACTIVE_O) |-> ##[0:2] (SUPPLY_ENABLE_O == 14'h0000); endproperty
   a_offen: assert property (p_offen) else $error("supplies left on at off");
   c_up: cover property ($rose(CHIP_ACTIVE_O));
   c_down: cover property ($fell(CHIP_ACTIVE_O));
   c_err: cover property (acc && PSLVERR_O);
endmodule // wake_seq_properties
bind wake_status_and_power_sequencer wake_seq_properties #(
   .SLOT_CYCLES(SLOT_CYCLES), .GPOFF_CYCLES(GPOFF_CYCLES)
) u_props (
   .REF_CLK_I(REF_CLK_I), .RST_N_I(RST_N_I), .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I),
   .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I), .PWDATA_I(PWDATA_I), .PRDATA_O(PRDATA_O),
   .PREADY_O(PREADY_O), .PSLVERR_O(PSLVERR_O), .GPIO_POWER_OFF_INPUT_I(GPIO_POWER_OFF_INPUT_I),
   .SHUTDOWN_FAULT_I(SHUTDOWN_FAULT_I), .THERMAL_SHUTDOWN_I(THERMAL_SHUTDOWN_I),
   .SUPPLY_ENABLE_O(SUPPLY_ENABLE_O), .FIRST_LEVEL_WAKE_IRQ_O(FIRST_LEVEL_WAKE_IRQ_O),
   .HOST_RESET_N_O(HOST_RESET_N_O), .MEMORY_RESET_OUT_N_O(MEMORY_RESET_OUT_N_O), .CHIP_ACTIVE_O(CHIP_ACTIVE_O)
);

// ### sim/wake_status_and_power_sequencer_test.sv
// self-checking bench for the wake status and power sequencer
`timescale 1ns/1ps
`include "wake_seq_defines.vh"
module wake_status_and_power_sequencer_test;
   localparam integer SLOT = 20;
   localparam integer KLONG = 60;
   localparam integer KSHORT = 30;
   reg          clk, rst_n, psel, pen, pwr, slow;
   reg  [11:0]  padr;
   reg  [31:0]  pwd;
   reg  [8:0]   ev;
   reg  [13:0]  smap;
   wire [31:0]  prdata;
   wire [13:0]  sen, sgood;
   wire         pready, pslverr, irq, hrst_n, mrst_n, act;
   integer      bad_count, checks_done, m;
   logic [33:0] q[$];
   logic [33:0] x;
   // ev: 0 wake, 1 power-on, 2 power-off, 3 conv, 4 wdog timeout, 5 thermal, 6 fault, 7 wdog reset, 8 key
   wake_status_and_power_sequencer #(.SLOT_CYCLES(SLOT), .START_CYCLES(5), .GPOFF_CYCLES(8),
      .KEY_LONG_CYC(KLONG), .KEY_SHORT_CYC(KSHORT)) u_dut (
      .REF_CLK_I(clk), .RST_N_I(rst_n), .PSEL_I(psel), .PENABLE_I(pen), .PWRITE_I(pwr), .PADDR_I(padr),
      .PWDATA_I(pwd), .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr), .POWER_KEY_I(~ev[8]),
      .GPIO_POWER_ON_INPUT_I(ev[1]), .GPIO_POWER_OFF_INPUT_I(ev[2]), .GPIO_WAKE_INPUT_I(ev[0]),
      .CONVERTER_FAULT_RESET_I(ev[3]), .WATCHDOG_RESET_I(ev[7]), .WATCHDOG_TIMEOUT_I(ev[4]),
      .SHUTDOWN_FAULT_I(ev[6]), .THERMAL_SHUTDOWN_I(ev[5]), .HIBERNATE_REQ_I(1'b0),
      .SLOT_SUPPLY_MAP_I(smap), .SUPPLY_GOOD_I(sgood), .SUPPLY_ENABLE_O(sen),
      .FIRST_LEVEL_WAKE_IRQ_O(irq), .HOST_RESET_N_O(hrst_n), .MEMORY_RESET_OUT_N_O(mrst_n), .CHIP_ACTIVE_O(act));
   supply_model u_supply (.clk_i(clk), .slow_i(slow), .enable_i(sen), .good_o(sgood));
   task cmp_w(input string nm, input [31:0] e, input [31:0] s);
      begin
         checks_done = checks_done + 1;
         if (s !== e) begin
            bad_count = bad_count + 1;
            $display("mismatch %s expected %h seen %h", nm, e, s);
         end
      end
   endtask
   task cmp_p(input string nm, input e, input s); cmp_w(nm, {31'h0, e}, {31'h0, s}); endtask
   task xfer(input w, input [11:0] a, input [31:0] d, input c, input [31:0] e, input er);
      integer k;
      begin
         q.push_back({c, er, e});
         @(posedge clk);
         psel <= 1'b1;
         pwr <= w;
         padr <= a;
         pwd <= d;
         @(posedge clk);
         pen <= 1'b1;
         k = 0;
         @(posedge clk);
         while (pready !== 1'b1 && k < 20) begin
            k = k + 1;
            @(posedge clk);
         end
         if (k >= 20) bad_count = bad_count + 1;
         psel <= 1'b0;
         pen <= 1'b0;
      end
   endtask
   task rd(input [11:0] a, input [31:0] e); xfer(1'b0, a, 32'h0, 1'b1, e, 1'b0); endtask
   task wr(input [11:0] a, input [31:0] d); xfer(1'b1, a, d, 1'b0, 32'h0, 1'b0); endtask
   always @(posedge clk) begin
      if (psel && pen && pready === 1'b1 && q.size() > 0) begin
         x = q.pop_front();
         if (x[33]) cmp_w("rdata", x[31:0], prdata);
         cmp_p("slverr", x[32], pslverr);
      end
   end
   task waitact(input v);
      integer k;
      begin
         for (k = 0; k < 2000 && act !== v; k = k + 1) @(posedge clk);
         cmp_p("active", v, act);
      end
   endtask
   task pulse(input integer i, input integer len);
      begin
         @(posedge clk);
         ev[i] <= 1'b1;
         repeat (len) @(posedge clk);
         ev[i] <= 1'b0;
      end
   endtask
   task start(input integer i, input [31:0] fl);
      begin
         slow <= $urandom % 2;
         smap <= 14'($urandom);
         pulse(i, 10);
         waitact(1'b1);
         repeat (3) @(posedge clk);
         cmp_p("irq set", 1'b1, irq);
         rd(`WAKE_STAT_ADDR, fl);
      end
   endtask
   task keyoff(input integer lo);
      integer k;
      begin
         for (k = 0; k < 300 && act === 1'b1; k = k + 1) @(posedge clk);
         ev[8] <= 1'b0;
         cmp_p("key hold", 1'b1, k >= lo - 4 && k <= lo + 12);
      end
   endtask
   task complete_run;
      begin
         $display("checks %0d mismatches %0d", checks_done, bad_count);
         if (bad_count == 0 && checks_done > 0) $display("[ PASS ]");
         else $display("[ FAIL ]");
         $finish;
      end
   endtask
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   initial begin
      repeat (20000) @(posedge clk);
      bad_count = bad_count + 1;
      complete_run;
   end
   initial begin
      {rst_n, psel, pen, pwr, slow, padr, pwd, ev, smap} = 0;
      bad_count = 0;
      checks_done = 0;
      void'($urandom(67));
      repeat (6) @(posedge clk);
      rst_n <= 1'b1;
      rd(`SYSCTL1_ADDR, 32'h0000_0002);
      rd(`WAKE_MASK_ADDR, 32'h0);
      xfer(1'b0, 12'h040, 32'h0, 1'b1, 32'h0, 1'b1);
      xfer(1'b1, 12'h044, 32'hFFFF, 1'b0, 32'h0, 1'b1);
      $display("test registers done");
      start(0, 32'h41);
      rd(`WAKE_STAT_ADDR, 32'h0);
      rd(`SYSCTL1_ADDR, 32'h8002);
      m = $urandom % 128;
      wr(`WAKE_MASK_ADDR, m);
      rd(`WAKE_MASK_ADDR, m);
      cmp_p("irq clear", 1'b0, irq);
      wr(`SYSCTL1_ADDR, 32'h0002);
      waitact(1'b0);
      cmp_p("host reset", 1'b0, hrst_n);
      cmp_p("mem reset", 1'b0, mrst_n);
      rd(`SYSCTL1_ADDR, 32'h0002);
      rd(`WAKE_MASK_ADDR, 32'h0);
      $display("test wake and software off done");
      pulse(8, 3);
      repeat (30) @(posedge clk);
      cmp_p("short key", 1'b0, act);
      start(8, 32'h42);
      ev[8] <= 1'b1;
      keyoff(KLONG);
      start(1, 32'h44);
      wr(`SYSCTL1_ADDR, 32'h800A);
      ev[8] <= 1'b1;
      keyoff(KSHORT);
      start(3, 32'h50);
      pulse(5, 2);
      waitact(1'b0);
      start(7, 32'h48);
      wr(`SYSCTL1_ADDR, 32'h8000);
      keyoff(KLONG);
      $display("test key and fault off done");
      start(0, 32'h41);
      repeat (7) pulse(4, 2);
      repeat (5) @(posedge clk);
      cmp_p("seven faults", 1'b1, act);
      pulse(4, 2);
      waitact(1'b0);
      start(0, 32'h41);
      pulse(2, 5);
      repeat (10) @(posedge clk);
      cmp_p("short off", 1'b1, act);
      pulse(2, 20);
      waitact(1'b0);
      start(1, 32'h44);
      pulse(6, 2);
      waitact(1'b0);
      $display("test watchdog and gpio off done");
      complete_run;
   end
endmodule // wake_status_and_power_sequencer_test
